// ===== hdl/msif_status_irq.sv
// Operating status and sticky interrupt flag registers of the motion sensor
// Functional notes
// - Reported mode may lag a mode command by up to three heartbeat transitions.
// - Sleep reports 000, standby 001; codes 011 and 100 never reported.
// - Activity watch 010 samples without queue, moves itself to continuous on activity.
// - Code 101 is continuous sampling; code 110 is combined mode.
// - Code 111 burst takes 1..254 or endless samples, finite burst returns to sleep.
// - New-sample bit 3 sets on fresh sample, clears on host read.
// - Queue-empty bit 4 is a level, reads 1 after reset.
// - Queue-full bit 5 is a level, 1 when 32 slots are used.
// - Queue-level bit 6 is 1 while count at or above threshold.
// - Pending bit 7 is the OR of all latched interrupt flags.
// - A flag latches only while its enable bit is 1.
// - I2C clears flags on read, or write if selected; SPI clears on write.
// - Wake flag bit 2 latches on automatic watch-to-continuous move.
// - Acquisition flag bit 3 latches on new sample in continuous or burst.
// - Queue-empty flag bit 4 re-arms only after non-empty then empty.
// - Queue-full flag bit 5 re-arms only after not-full then full.
// - Queue-level flag bit 6 latches while count at or above the threshold, with no re-arm.
// - Combined detect flag bit 7 latches in combined mode; detector then halts.
// - With re-arm option set, clearing combined flag resets the detector.
// - Without re-arm option, detector restarts only when leaving combined mode.
`timescale 1ns/1ps
`default_nettype none
module msif_status_irq
   import msif_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic heartbeat,
   input wire logic mode_cmd_valid,
   input wire logic [MSIF_MODE_W-1:0] mode_cmd,
   input wire logic [7:0] burst_length,
   input wire logic activity_detected,
   input wire logic sample_acquired,
   input wire logic [MSIF_COUNT_W-1:0] queue_count,
   input wire logic [MSIF_THRESH_W-1:0] queue_threshold,
   input wire logic [MSIF_FLAG_COUNT-1:0] irq_enable,
   input wire logic detector_rearm_on_clear,
   input wire logic write_clear_select,
   input wire logic spi_selected,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   output logic [7:0] reg_rdata,
   output logic [7:0] operating_status,
   output logic [7:0] interrupt_pending_status,
   output logic any_irq_pending,
   output logic [MSIF_MODE_W-1:0] current_mode,
   output logic detector_armed
);

   typedef struct packed {
      logic hb_prev;
      logic [1:0] settle;
      logic cmd_pending;
      msif_mode_e cmd_mode;
      msif_mode_e mode;
      logic [7:0] burst_left;
      logic burst_endless;
      logic new_sample;
      logic [MSIF_FLAG_COUNT-1:0] flags;
      logic empty_armed;
      logic full_armed;
      logic armed;
      logic [7:0] rdata;
      logic [7:0] op_stat;
      logic [7:0] irq_stat;
      logic pending;
   } msif_state_s;

   msif_state_s cur;
   msif_state_s next_cur;
   logic hb_sync;

   msif_sync #(
      .RESET_VALUE(1'b0)
   ) u_hb_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(heartbeat),
      .sync_out(hb_sync)
   );

   always_comb begin
      logic hb_edge;
      logic queue_empty;
      logic queue_full;
      logic queue_level;
      logic status_rd;
      logic status_clear;
      logic wake_evt;
      logic combined_evt;
      logic [MSIF_FLAG_COUNT-1:0] events;
      logic [7:0] op_view;
      logic [7:0] irq_view;
      hb_edge = 1'b0;
      queue_empty = 1'b0;
      queue_full = 1'b0;
      queue_level = 1'b0;
      status_rd = 1'b0;
      status_clear = 1'b0;
      wake_evt = 1'b0;
      combined_evt = 1'b0;
      events = '0;
      op_view = '0;
      irq_view = '0;
      next_cur = cur;

      hb_edge = hb_sync != cur.hb_prev;
      next_cur.hb_prev = hb_sync;

      queue_empty = queue_count == MSIF_QUEUE_EMPTY_COUNT;
      queue_full = queue_count == MSIF_QUEUE_FULL_COUNT;
      queue_level = queue_count >= {1'b0, queue_threshold};

      status_rd = reg_rd && reg_addr == MSIF_ADDR_INTERRUPT_PENDING_STATUS;
      // SPI always clears by write; I2C by read unless write clearing is selected
      if (spi_selected || write_clear_select) begin
         status_clear = reg_wr && reg_addr == MSIF_ADDR_INTERRUPT_PENDING_STATUS;
      end else begin
         status_clear = status_rd;
      end

      // Mode commands are applied on a later heartbeat transition, never reserved codes
      if (mode_cmd_valid && mode_cmd != MSIF_MODE_RESV3 && mode_cmd != MSIF_MODE_RESV4) begin
         next_cur.cmd_pending = 1'b1;
         next_cur.cmd_mode = msif_mode_e'(mode_cmd);
         next_cur.settle = '0;
      end else if (cur.cmd_pending && hb_edge) begin
         if (cur.settle == MSIF_MODE_SETTLE_MAX - 2'h1) begin
            next_cur.cmd_pending = 1'b0;
            next_cur.mode = cur.cmd_mode;
            next_cur.settle = '0;
            if (cur.cmd_mode == MSIF_MODE_BURST) begin
               next_cur.burst_endless = burst_length == MSIF_BURST_CONTINUOUS;
               next_cur.burst_left = (burst_length > MSIF_BURST_MAX) ? MSIF_BURST_MAX : burst_length;
            end
         end else begin
            next_cur.settle = cur.settle + 2'h1;
         end
      end

      unique case (cur.mode)
         MSIF_MODE_ACTIVITY_WATCH: begin
            // Self-driven move, the only source of the wake event
            if (activity_detected && !cur.cmd_pending) begin
               next_cur.mode = MSIF_MODE_CONTINUOUS;
               wake_evt = 1'b1;
            end
         end
         MSIF_MODE_COMBINED: begin
            if (activity_detected && cur.armed) begin
               combined_evt = 1'b1;
               next_cur.armed = 1'b0;
            end
         end
         MSIF_MODE_BURST: begin
            if (sample_acquired && !cur.burst_endless) begin
               if (cur.burst_left <= 8'h01) begin
                  next_cur.mode = MSIF_MODE_SLEEP;
               end else begin
                  next_cur.burst_left = cur.burst_left - 8'h01;
               end
            end
         end
         MSIF_MODE_SLEEP, MSIF_MODE_STANDBY, MSIF_MODE_CONTINUOUS: begin
         end
         default: begin
            next_cur.mode = MSIF_MODE_SLEEP;
         end
      endcase

      // Leaving combined mode always resets the detector
      if (cur.mode != MSIF_MODE_COMBINED) begin
         next_cur.armed = 1'b1;
      end

      events[MSIF_WAKE_BIT-MSIF_FLAG_LO] = wake_evt;
      events[MSIF_ACQ_BIT-MSIF_FLAG_LO] = sample_acquired &&
         (cur.mode == MSIF_MODE_CONTINUOUS || cur.mode == MSIF_MODE_BURST);
      events[MSIF_QEMPTY_IRQ_BIT-MSIF_FLAG_LO] = queue_empty && cur.empty_armed;
      events[MSIF_QFULL_IRQ_BIT-MSIF_FLAG_LO] = queue_full && cur.full_armed;
      events[MSIF_QLEVEL_IRQ_BIT-MSIF_FLAG_LO] = queue_level;
      events[MSIF_COMBINED_BIT-MSIF_FLAG_LO] = combined_evt;

      // Edge arming keeps the empty and full conditions from retriggering after a clear
      if (queue_empty && cur.empty_armed) begin
         next_cur.empty_armed = 1'b0;
      end else if (!queue_empty) begin
         next_cur.empty_armed = 1'b1;
      end
      if (queue_full && cur.full_armed) begin
         next_cur.full_armed = 1'b0;
      end else if (!queue_full) begin
         next_cur.full_armed = 1'b1;
      end

      if (status_clear) begin
         next_cur.flags = '0;
         if (detector_rearm_on_clear && cur.flags[MSIF_COMBINED_BIT-MSIF_FLAG_LO]) begin
            next_cur.armed = 1'b1;
         end
      end
      // Set is applied after clear so a coincident event survives
      next_cur.flags = next_cur.flags | (events & irq_enable);

      if (sample_acquired) begin
         next_cur.new_sample = 1'b1;
      end else if (reg_rd && reg_addr == MSIF_ADDR_OPERATING_STATUS) begin
         next_cur.new_sample = 1'b0;
      end

      next_cur.pending = |next_cur.flags;

      op_view = {next_cur.pending, queue_level, queue_full, queue_empty,
                 next_cur.new_sample, next_cur.mode};
      irq_view = {next_cur.flags, 2'b00};
      next_cur.op_stat = op_view;
      next_cur.irq_stat = irq_view;

      // Read data shows the value before any clear caused by this read
      if (reg_rd && reg_addr == MSIF_ADDR_OPERATING_STATUS) begin
         next_cur.rdata = cur.op_stat;
      end else if (status_rd) begin
         next_cur.rdata = cur.irq_stat;
      end else if (reg_rd) begin
         next_cur.rdata = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur <= '{
            hb_prev: 1'b0,
            settle: 2'h0,
            cmd_pending: 1'b0,
            cmd_mode: MSIF_MODE_SLEEP,
            mode: MSIF_MODE_SLEEP,
            burst_left: 8'h00,
            burst_endless: 1'b0,
            new_sample: 1'b0,
            flags: '0,
            empty_armed: 1'b1,
            full_armed: 1'b1,
            armed: 1'b1,
            rdata: 8'h00,
            op_stat: MSIF_OPERATING_STATUS_RESET | (8'h01 << MSIF_QUEUE_EMPTY_BIT),
            irq_stat: MSIF_INTERRUPT_PENDING_RESET,
            pending: 1'b0
         };
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rdata = cur.rdata;
   assign operating_status = cur.op_stat;
   assign interrupt_pending_status = cur.irq_stat;
   assign any_irq_pending = cur.pending;
   assign current_mode = cur.mode;
   assign detector_armed = cur.armed;

endmodule : msif_status_irq
`default_nettype wire

// ===== hdl/msif_pkg.sv
// Package with register map, field positions and mode codes for the status and interrupt flag block
package msif_pkg;

   localparam logic [7:0] MSIF_ADDR_OPERATING_STATUS = 8'h08;
   localparam logic [7:0] MSIF_ADDR_INTERRUPT_PENDING_STATUS = 8'h09;
   localparam logic [7:0] MSIF_OPERATING_STATUS_RESET = 8'h00;
   localparam logic [7:0] MSIF_INTERRUPT_PENDING_RESET = 8'h00;

   // Operating status field positions
   localparam int MSIF_NEW_SAMPLE_BIT = 3;
   localparam int MSIF_QUEUE_EMPTY_BIT = 4;
   localparam int MSIF_QUEUE_FULL_BIT = 5;
   localparam int MSIF_QUEUE_LEVEL_BIT = 6;
   localparam int MSIF_PENDING_BIT = 7;

   // Interrupt pending field positions
   localparam int MSIF_WAKE_BIT = 2;
   localparam int MSIF_ACQ_BIT = 3;
   localparam int MSIF_QEMPTY_IRQ_BIT = 4;
   localparam int MSIF_QFULL_IRQ_BIT = 5;
   localparam int MSIF_QLEVEL_IRQ_BIT = 6;
   localparam int MSIF_COMBINED_BIT = 7;
   localparam int MSIF_FLAG_LO = 2;
   localparam int MSIF_FLAG_COUNT = 6;

   localparam int MSIF_QUEUE_DEPTH = 32;
   localparam int MSIF_COUNT_W = 6;
   localparam int MSIF_THRESH_W = 5;
   localparam logic [MSIF_COUNT_W-1:0] MSIF_QUEUE_FULL_COUNT = 6'h20;
   localparam logic [MSIF_COUNT_W-1:0] MSIF_QUEUE_EMPTY_COUNT = 6'h00;

   // Mode field settles within this many heartbeat transitions
   localparam int MSIF_MODE_SETTLE_TRANSITIONS = 3;
   localparam logic [1:0] MSIF_MODE_SETTLE_MAX = 2'h3;

   localparam int MSIF_SYNC_STAGES = 3;
   localparam int MSIF_MODE_W = 3;

   typedef enum logic [2:0] {
      MSIF_MODE_SLEEP = 3'b000,
      MSIF_MODE_STANDBY = 3'b001,
      MSIF_MODE_ACTIVITY_WATCH = 3'b010,
      MSIF_MODE_RESV3 = 3'b011,
      MSIF_MODE_RESV4 = 3'b100,
      MSIF_MODE_CONTINUOUS = 3'b101,
      MSIF_MODE_COMBINED = 3'b110,
      MSIF_MODE_BURST = 3'b111
   } msif_mode_e;

   localparam logic [7:0] MSIF_BURST_MAX = 8'hFE;
   localparam logic [7:0] MSIF_BURST_CONTINUOUS = 8'h00;

endpackage : msif_pkg

// ===== hdl/msif_sync.sv
// Three stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module msif_sync
   import msif_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);

   typedef struct packed {
      logic [MSIF_SYNC_STAGES-1:0] stage;
      logic level;
   } msif_sync_s;

   msif_sync_s cur;
   msif_sync_s next_cur;

   // Stage 0 is only read by stage 1; the level follows once stages 1 and 2 agree
   always_comb begin
      next_cur = cur;
      next_cur.stage = {cur.stage[MSIF_SYNC_STAGES-2:0], async_in};
      if (cur.stage[1] == cur.stage[2]) begin
         next_cur.level = cur.stage[2];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur <= '{stage: {MSIF_SYNC_STAGES{RESET_VALUE}}, level: RESET_VALUE};
      end else begin
         cur <= next_cur;
      end
   end

   assign sync_out = cur.level;

endmodule : msif_sync
`default_nettype wire

// ===== tb/msif_status_irq_props.sv
// Checker for the status and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module msif_status_irq_props
   import msif_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [MSIF_COUNT_W-1:0] queue_count,
   input wire logic [MSIF_THRESH_W-1:0] queue_threshold,
   input wire logic [MSIF_FLAG_COUNT-1:0] irq_enable,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] operating_status,
   input wire logic [7:0] interrupt_pending_status,
   input wire logic any_irq_pending,
   input wire logic [MSIF_MODE_W-1:0] current_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_pending_is_or: assert property (any_irq_pending == (|interrupt_pending_status) &&
      operating_status[MSIF_PENDING_BIT] == (|interrupt_pending_status)) else $error("pending bit not OR of flags");
   a_resv_bits_zero: assert property (interrupt_pending_status[1:0] == 2'h0) else $error("reserved flag bits set");
   a_mode_not_resv: assert property (current_mode != MSIF_MODE_RESV3 && current_mode != MSIF_MODE_RESV4)
      else $error("reserved mode reported");
   a_full_level: assert property (operating_status[MSIF_QUEUE_FULL_BIT] ==
      ($past(queue_count) == MSIF_QUEUE_FULL_COUNT)) else $error("full level wrong");
   a_empty_level: assert property (operating_status[MSIF_QUEUE_EMPTY_BIT] ==
      ($past(queue_count) == MSIF_QUEUE_EMPTY_COUNT)) else $error("empty level wrong");
   a_thresh_level: assert property (operating_status[MSIF_QUEUE_LEVEL_BIT] ==
      ($past(queue_count) >= $past(queue_threshold))) else $error("threshold level wrong");
   a_enable_gates_set: assert property ((interrupt_pending_status[7:2] & ~$past(interrupt_pending_status[7:2])
      & ~$past(irq_enable)) == 6'h00) else $error("flag set while disabled");
   a_read_flags_data: assert property (reg_rd && reg_addr == MSIF_ADDR_INTERRUPT_PENDING_STATUS |=>
      reg_rdata == $past(interrupt_pending_status)) else $error("flag read data wrong");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data changed without read");
endmodule : msif_status_irq_props
bind msif_status_irq msif_status_irq_props i_props (.*);
`default_nettype wire

// ===== tb/msif_host_model.sv
// Host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module msif_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_addr
);
   // Idle address carries junk so nothing leans on a stale value
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'hA5;
   end
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
   task automatic wr(input logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
   endtask : wr
endmodule : msif_host_model
`default_nettype wire

// ===== tb/tb.sv
// Testbench for the status and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb
   import msif_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] hb_cnt = 3'h0;
   logic mode_cmd_valid = 1'b0;
   logic [2:0] mode_cmd = 3'h0;
   logic activity_detected = 1'b0;
   logic sample_acquired = 1'b0;
   logic [5:0] queue_count = 6'h00;
   logic [4:0] queue_threshold = 5'h10;
   logic [5:0] irq_enable = 6'h00;
   logic write_clear_select = 1'b0;
   logic spi_selected = 1'b0;
   logic [7:0] burst_length = 8'h00;
   logic detector_rearm_on_clear = 1'b0;
   logic reg_rd, reg_wr, any_irq_pending, detector_armed;
   logic [7:0] reg_addr, reg_rdata, operating_status, interrupt_pending_status, d;
   logic [2:0] current_mode;
   int bad_count = 0;
   int total_checks = 0;
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // Heartbeat runs free and slow against the core clock
   always @(negedge ref_clk) hb_cnt <= hb_cnt + 3'h1;
   msif_status_irq i_dut (.*, .heartbeat(hb_cnt[2]));
   msif_host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic [2:0] m);
      mode_cmd = m;
      mode_cmd_valid = 1'b1;
      @(negedge ref_clk);
      mode_cmd_valid = 1'b0;
      repeat (20) @(negedge ref_clk);
   endtask : cmd
   task automatic pulse(input logic act);
      activity_detected = act;
      sample_acquired = !act;
      @(negedge ref_clk);
      activity_detected = 1'b0;
      sample_acquired = 1'b0;
      @(negedge ref_clk);
   endtask : pulse
   task automatic qev();
      queue_count = 6'h01;
      @(negedge ref_clk);
      queue_count = 6'h00;
      repeat (2) @(negedge ref_clk);
   endtask : qev
   initial begin
      repeat (3000) @(posedge ref_clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(operating_status, 8'h10);
      chk(interrupt_pending_status, 8'h00);
      i_host.rd(MSIF_ADDR_OPERATING_STATUS, d);
      chk(d, 8'h10);
      i_host.rd(8'h3F, d);
      chk(d, 8'h00);
      cmd(MSIF_MODE_STANDBY);
      chk(current_mode, MSIF_MODE_STANDBY);
      cmd(MSIF_MODE_RESV3);
      chk(current_mode, MSIF_MODE_STANDBY);
      cmd(MSIF_MODE_RESV4);
      chk(current_mode, MSIF_MODE_STANDBY);
      cmd(MSIF_MODE_SLEEP);
      chk(current_mode, MSIF_MODE_SLEEP);
      irq_enable = 6'h3F;
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      chk(interrupt_pending_status[4], 1'b0);
      queue_count = 6'h20;
      repeat (2) @(negedge ref_clk);
      chk(operating_status[6:4], 3'b110);
      chk(interrupt_pending_status[6:5], 2'b11);
      chk(any_irq_pending, 1'b1);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      chk(d[6:5], 2'b11);
      chk(interrupt_pending_status[5], 1'b0);
      queue_count = 6'h1F;
      @(negedge ref_clk);
      queue_count = 6'h20;
      repeat (2) @(negedge ref_clk);
      chk(interrupt_pending_status[5], 1'b1);
      queue_count = 6'h00;
      repeat (2) @(negedge ref_clk);
      chk(interrupt_pending_status[5:4], 2'b11);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      // Read clear, then write clear on the first and on the second interface
      for (int i = 0; i < 3; i++) begin
         {spi_selected, write_clear_select} = 2'(i);
         qev();
         if (i == 0) i_host.wr(MSIF_ADDR_INTERRUPT_PENDING_STATUS);
         else i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
         chk(interrupt_pending_status[4], 1'b1);
         if (i == 0) i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
         else i_host.wr(MSIF_ADDR_INTERRUPT_PENDING_STATUS);
         chk(interrupt_pending_status[4], 1'b0);
      end
      {spi_selected, write_clear_select} = 2'b00;
      irq_enable = 6'h3B;
      qev();
      chk(interrupt_pending_status[4], 1'b0);
      irq_enable = 6'h3F;
      pulse(1'b0);
      chk(operating_status[3], 1'b1);
      chk(interrupt_pending_status[3], 1'b0);
      i_host.rd(MSIF_ADDR_OPERATING_STATUS, d);
      chk(d[3], 1'b1);
      chk(operating_status[3], 1'b0);
      cmd(MSIF_MODE_CONTINUOUS);
      pulse(1'b0);
      chk(interrupt_pending_status[3], 1'b1);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      cmd(MSIF_MODE_ACTIVITY_WATCH);
      pulse(1'b1);
      repeat (20) @(negedge ref_clk);
      chk(current_mode, MSIF_MODE_CONTINUOUS);
      chk(interrupt_pending_status[2], 1'b1);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      cmd(MSIF_MODE_COMBINED);
      chk(current_mode, MSIF_MODE_COMBINED);
      pulse(1'b1);
      chk(interrupt_pending_status[7], 1'b1);
      chk(detector_armed, 1'b0);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      chk(detector_armed, 1'b0);
      cmd(MSIF_MODE_CONTINUOUS);
      chk(detector_armed, 1'b1);
      cmd(MSIF_MODE_BURST);
      chk(current_mode, MSIF_MODE_BURST);
      pulse(1'b0);
      chk(interrupt_pending_status[3], 1'b1);
      // A sample lands in the same cycle as the clearing read: it must stay latched
      fork
         i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
         begin
            @(negedge ref_clk);
            sample_acquired = 1'b1;
            @(negedge ref_clk);
            sample_acquired = 1'b0;
         end
      join
      chk(d[3], 1'b1);
      chk(interrupt_pending_status[3], 1'b1);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      chk(interrupt_pending_status[3], 1'b0);
      // Finite burst of one sample falls back to sleep by itself
      burst_length = 8'h01;
      cmd(MSIF_MODE_BURST);
      chk(current_mode, MSIF_MODE_BURST);
      pulse(1'b0);
      chk(current_mode, MSIF_MODE_SLEEP);
      // With the re-arm option, clearing the combined flag restarts detection
      detector_rearm_on_clear = 1'b1;
      cmd(MSIF_MODE_COMBINED);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      pulse(1'b1);
      chk(interrupt_pending_status[7], 1'b1);
      chk(detector_armed, 1'b0);
      i_host.rd(MSIF_ADDR_INTERRUPT_PENDING_STATUS, d);
      chk(detector_armed, 1'b1);
      pulse(1'b1);
      chk(interrupt_pending_status[7], 1'b1);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
